// file: sim/encoder_counter_timer_logic_bench.sv
// self-checking bench for the encoder, counter, timer and logic cell
`timescale 1ns/1ps
module encoder_counter_timer_logic_bench;
  logic core_clk, rst, quad_counting_method, quad_direction_policy, quad_soft_clear;
  logic quad_load, count_soft_clear, count_load, tmr_soft_clear, tmr_load, enc_a, enc_b;
  logic truth_table_entry_write, truth_table_entry_bit, truth_table_all_write, cell_output;
  logic quad_output_pulse, count_terminal_event, tmr_active, truth_table_read_bit;
  logic [7:0] src_signals, drv;
  logic [2:0] quad_a_input_pick, quad_b_input_pick, quad_clear_source, count_increment_source;
  logic [2:0] count_clear_source, tmr_start_source;
  logic [31:0] quad_output_ratio, quad_load_value, quad_position_count, count_target_length;
  logic [31:0] count_load_value, count_present_value, tmr_start_delay_us, tmr_pulse_length_us;
  logic [31:0] tmr_load_value, tmr_present_value_us;
  logic [1:0] cell_combine_function, cell_input_negate, truth_table_entry_index;
  logic [1:0] cell_active_input_count;
  logic [5:0] cell_input_pick;
  logic [3:0] truth_table_all_bits, truth_table_value;
  int err_total, cmp_count, npulse, nterm, n;
  // encoder a on source 5, b on source 2, the rest from the bench
  assign src_signals = {drv[7:6], enc_a, drv[4:3], enc_b, drv[1:0]};
  encoder_counter_timer_logic i_dut (.*);
  quad_encoder_model i_enc (.core_clk(core_clk), .enc_a(enc_a), .enc_b(enc_b));
  // 10 mhz clock
  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end
  // output pulse and terminal event tallies, sampled mid-cycle once settled
  always @(negedge core_clk) begin
    if (quad_output_pulse === 1'h1) npulse++;
    if (count_terminal_event === 1'h1) nterm++;
  end
  // ----------------
  // helpers
  // ----------------
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic strobe(ref logic s);
    s = 1'h1;
    tick(1);
    s = 1'h0;
  endtask
  task automatic pulse(input int b);
    drv[b] = 1'h1;
    tick(2);
    drv[b] = 1'h0;
    tick(2);
  endtask
  task automatic tmr_run;
    n = 0;
    while (tmr_active !== 1'h1 && n < 99) begin
      tick(1);
      n++;
    end
    chk_bit(n inside {[27:34]}, 1'h1);
    n = 0;
    while (tmr_active === 1'h1 && n < 99) begin
      tick(1);
      n++;
    end
    chk_bit(n inside {[19:21]}, 1'h1);
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_edge;
    quad_counting_method = 1'h1;
    quad_direction_policy = 1'h1;
    i_enc.move(8, 1'h1);
    tick(4);
    chk(quad_position_count, 32'h8);
    i_enc.move(3, 1'h0);
    tick(4);
    chk(quad_position_count, 32'h5);
    chk(npulse, 32'h2);
  endtask
  task automatic t_dir;
    strobe(quad_soft_clear);
    tick(1);
    chk(quad_position_count, 32'h0);
    quad_direction_policy = 1'h0;
    i_enc.move(4, 1'h1);
    i_enc.move(3, 1'h0);
    tick(4);
    chk(quad_position_count, 32'h4);
    i_enc.move(2, 1'h1);
    tick(4);
    chk(quad_position_count, 32'h6);
  endtask
  task automatic t_full;
    quad_counting_method = 1'h0;
    quad_direction_policy = 1'h1;
    quad_load_value = 32'h64;
    strobe(quad_load);
    tick(1);
    chk(quad_position_count, 32'h64);
    i_enc.move(2, 1'h1);
    i_enc.move(1, 1'h0);
    i_enc.move(7, 1'h1);
    tick(4);
    chk(quad_position_count, 32'h66);
    i_enc.move(4, 1'h0);
    tick(4);
    chk(quad_position_count, 32'h65);
    pulse(7);
    tick(2);
    chk(quad_position_count, 32'h0);
  endtask
  task automatic t_cnt;
    repeat (5) pulse(3);
    chk(count_present_value, 32'h5);
    chk(nterm, 32'h1);
    strobe(count_soft_clear);
    chk(count_present_value, 32'h0);
    count_load_value = 32'h3;
    strobe(count_load);
    tick(1);
    chk(count_present_value, 32'h3);
    pulse(0);
    repeat (2) pulse(3);
    chk(count_present_value, 32'h5);
    chk(nterm, 32'h2);
    pulse(4);
    chk(count_present_value, 32'h0);
  endtask
  task automatic t_tmr;
    drv[6] = 1'h1;
    tmr_run();
    drv[6] = 1'h0;
    strobe(tmr_soft_clear);
    chk(tmr_present_value_us, 32'h0);
    tmr_run();
    tmr_load_value = 32'h5;
    strobe(tmr_load);
    chk(tmr_present_value_us, 32'h5);
  endtask
  task automatic t_cell;
    logic a, b;
    logic [3:0] tbl;
    tbl = 4'h7;
    truth_table_all_bits = 4'h6;
    strobe(truth_table_all_write);
    truth_table_entry_bit = 1'h1;
    strobe(truth_table_entry_write);
    tick(1);
    chk({28'h0, truth_table_value}, 32'h7);
    chk_bit(truth_table_read_bit, 1'h1);
    truth_table_entry_index = 2'h3;
    tick(2);
    chk_bit(truth_table_read_bit, 1'h0);
    chk({30'h0, cell_active_input_count}, 32'h2);
    for (int f = 0; f < 4; f++) begin
      for (int k = 0; k < 16; k++) begin
        cell_combine_function = f[1:0];
        cell_input_negate = k[3:2];
        drv[0] = k[1];
        drv[1] = k[0];
        tick(3);
        a = k[1] ^ k[3];
        b = k[0] ^ k[2];
        chk_bit(cell_output, f == 0 ? a & b : f == 1 ? a | b : f == 2 ? tbl[{a, b}] : 1'h0);
      end
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (40000) @(posedge core_clk);
    err_total++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    rst = 1'h1;
    {quad_counting_method, quad_direction_policy, quad_soft_clear, quad_load, count_soft_clear,
      count_load, tmr_soft_clear, tmr_load, truth_table_entry_write, truth_table_entry_bit,
      truth_table_all_write, drv, quad_load_value, count_load_value, tmr_load_value,
      cell_combine_function, cell_input_negate, truth_table_entry_index,
      truth_table_all_bits} = '0;
    quad_a_input_pick = 3'h5;
    quad_b_input_pick = 3'h2;
    quad_clear_source = 3'h7;
    quad_output_ratio = 32'h4;
    count_increment_source = 3'h3;
    count_clear_source = 3'h4;
    count_target_length = 32'h5;
    tmr_start_source = 3'h6;
    tmr_start_delay_us = 32'h3;
    tmr_pulse_length_us = 32'h2;
    cell_input_pick = 6'h01;
    tick(16);
    rst = 1'h0;
    tick(1);
    t_edge();
    t_dir();
    t_full();
    t_cnt();
    t_tmr();
    t_cell();
    tally_and_finish();
  end
endmodule

// file: sim/encoder_counter_timer_logic_chk.sv
// port-level assertions for the trigger logic
`timescale 1ns/1ps
module encoder_counter_timer_logic_chk
  import trig_logic_pkg::*;
#(
  parameter int NSRC = NUM_SRC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // watched control
  input wire logic [NSRC-1:0] src_signals,
  input wire logic quad_soft_clear,
  input wire logic quad_load,
  input wire logic count_soft_clear,
  input wire logic [CNT_W-1:0] count_target_length,
  input wire logic tmr_soft_clear,
  input wire logic tmr_load,
  input wire logic [TMR_W-1:0] tmr_pulse_length_us,
  input wire logic [1:0] cell_combine_function,
  input wire logic [2*SRC_W-1:0] cell_input_pick,
  input wire logic [CELL_INPUTS-1:0] cell_input_negate,
  // watched status
  input wire logic [QUAD_W-1:0] quad_position_count,
  input wire logic [CNT_W-1:0] count_present_value,
  input wire logic count_terminal_event,
  input wire logic [TMR_W-1:0] tmr_present_value_us,
  input wire logic tmr_active,
  input wire logic [3:0] truth_table_value,
  input wire logic [1:0] cell_active_input_count,
  input wire logic cell_output
);
  logic in_a;
  logic in_b;
  logic cell_exp;
  // expected cell result from picked, negated inputs
  assign in_a = src_signals[cell_input_pick[5:3]] ^ cell_input_negate[1];
  assign in_b = src_signals[cell_input_pick[2:0]] ^ cell_input_negate[0];
  assign cell_exp = (cell_combine_function == CELL_AND) ? (in_a & in_b) :
    (cell_combine_function == CELL_OR) ? (in_a | in_b) :
    (cell_combine_function == CELL_TABLE) ? truth_table_value[{in_a, in_b}] : 1'h0;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // timer pulse start, then eight quiet cycles
  sequence seq_pulse_start;
    $rose(tmr_active) && (tmr_pulse_length_us != 32'h0);
  endsequence
  sequence seq_quiet;
    (!tmr_soft_clear && !tmr_load)[*8];
  endsequence
  // ----------------
  // assertions
  // ----------------
  AST_CELL_FN: assert property (
    !$past(rst) |-> cell_output == $past(cell_exp)) else $error("cell output mismatch");
  AST_CELL_CNT: assert property (cell_active_input_count == CELL_INPUT_COUNT)
    else $error("input count wrong");
  AST_CNT_TERM: assert property (
    count_terminal_event |-> count_present_value == count_target_length)
    else $error("terminal event off target");
  AST_CNT_CLR: assert property (count_soft_clear |=> count_present_value == 32'h0)
    else $error("counter not cleared");
  AST_QUAD_CLR: assert property (quad_soft_clear |=> quad_position_count == 32'h0)
    else $error("position not cleared");
  AST_QUAD_STEP: assert property (
    $changed(quad_position_count) && !$past(quad_load) && !$past(quad_soft_clear)
    && !$past(rst) |-> quad_position_count == 32'h0 ||
    (quad_position_count - $past(quad_position_count)) inside {32'h1, 32'hffff_ffff})
    else $error("position jumped");
  AST_TMR_CLR: assert property (
    tmr_soft_clear |=> !tmr_active && tmr_present_value_us == 32'h0)
    else $error("timer not cleared");
  AST_TMR_LEN: assert property (seq_pulse_start ##1 seq_quiet |-> tmr_active)
    else $error("timer pulse too short");
endmodule
bind encoder_counter_timer_logic encoder_counter_timer_logic_chk #(.NSRC(NSRC)) i_chk (.*);

// file: sim/quad_encoder_model.sv
// behavioural incremental encoder driving the a/b lines
`timescale 1ns/1ps
module quad_encoder_model #(
  parameter int EDGE_GAP = 334
) (
  // clock
  input wire logic core_clk,
  // encoder lines
  output logic enc_a,
  output logic enc_b
);
  logic [1:0] phase_reg = 2'h0;
  // forward phase order gives ab = 00 10 11 01
  assign enc_a = ^phase_reg;
  assign enc_b = phase_reg[1];
  // one quarter step per loop, spaced to keep the edge rate near 30 kHz
  task automatic move(input int n, input logic fwd);
    repeat (n) begin
      repeat (EDGE_GAP) @(posedge core_clk);
      #1;
      phase_reg = fwd ? phase_reg + 2'h1 : phase_reg - 2'h1;
    end
  endtask
endmodule

// file: src/encoder_counter_timer_logic.sv
// encoder interface, event counter, delay/pulse timer and logic cell
//
// Functional notes
// - every-edge method counts each transition of a or b
// - full-cycle method counts once per 00 10 11 01 cycle, jitter filtered
// - direction policy counts up forward, holds during reverse
// - position policy counts up forward and down in reverse
// - method input selects full-cycle or every-edge counting
// - one output pulse per programmed number of counted steps
// - a and b inputs each pick their own source signal
// - position count readable and loadable
// - selected clear source or soft clear zeroes the position count
// - counter advances on its selected event source
// - counter raises terminal event after programmed event count
// - counter value readable and loadable
// - selected clear source or soft clear zeroes the counter
// - timer starts on its selected trigger source
// - timer waits programmed delay in microseconds before pulse
// - timer pulse lasts programmed microseconds
// - timer value readable, loadable; soft clear restarts it
// - logic cell offers and, or and truth table functions
// - table index is a as high bit, b as low bit
// - table writable per entry by index or all at once
// - each cell input picks a source, optional inversion; count reported
`timescale 1ns/1ps
module encoder_counter_timer_logic
  import trig_logic_pkg::*;
#(
  parameter int NSRC = NUM_SRC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // candidate source signals (lines and internal events)
  input wire logic [NSRC-1:0] src_signals,
  // encoder control
  input wire logic [SRC_W-1:0] quad_a_input_pick,
  input wire logic [SRC_W-1:0] quad_b_input_pick,
  input wire logic quad_counting_method,
  input wire logic quad_direction_policy,
  input wire logic [QUAD_W-1:0] quad_output_ratio,
  input wire logic [SRC_W-1:0] quad_clear_source,
  input wire logic quad_soft_clear,
  input wire logic quad_load,
  input wire logic [QUAD_W-1:0] quad_load_value,
  // encoder status
  output logic [QUAD_W-1:0] quad_position_count,
  output logic quad_output_pulse,
  // counter control
  input wire logic [SRC_W-1:0] count_increment_source,
  input wire logic [SRC_W-1:0] count_clear_source,
  input wire logic [CNT_W-1:0] count_target_length,
  input wire logic count_soft_clear,
  input wire logic count_load,
  input wire logic [CNT_W-1:0] count_load_value,
  // counter status
  output logic [CNT_W-1:0] count_present_value,
  output logic count_terminal_event,
  // timer control
  input wire logic [SRC_W-1:0] tmr_start_source,
  input wire logic [TMR_W-1:0] tmr_start_delay_us,
  input wire logic [TMR_W-1:0] tmr_pulse_length_us,
  input wire logic tmr_soft_clear,
  input wire logic tmr_load,
  input wire logic [TMR_W-1:0] tmr_load_value,
  // timer status
  output logic [TMR_W-1:0] tmr_present_value_us,
  output logic tmr_active,
  // logic cell control
  input wire logic [1:0] cell_combine_function,
  input wire logic [2*SRC_W-1:0] cell_input_pick,
  input wire logic [CELL_INPUTS-1:0] cell_input_negate,
  input wire logic [1:0] truth_table_entry_index,
  input wire logic truth_table_entry_write,
  input wire logic truth_table_entry_bit,
  input wire logic truth_table_all_write,
  input wire logic [3:0] truth_table_all_bits,
  // logic cell status
  output logic truth_table_read_bit,
  output logic [3:0] truth_table_value,
  output logic [1:0] cell_active_input_count,
  output logic cell_output
);

  // ---------------------------------------------------------------
  // source selection and edge detection
  // ---------------------------------------------------------------
  logic [NSRC-1:0] src_prev_reg, src_prev_next;
  logic [NSRC-1:0] src_rise;

  // rising edges of every source, one per bit
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_rise
      assign src_rise[gi] = src_signals[gi] & ~src_prev_reg[gi];
    end
  endgenerate

  always_comb begin
    src_prev_next = src_signals;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      src_prev_reg <= '0;
    end else begin
      src_prev_reg <= src_prev_next;
    end
  end

  // ---------------------------------------------------------------
  // encoder interface
  // ---------------------------------------------------------------
  logic quad_a, quad_b;
  logic step_fwd, step_rev;
  logic quad_clear;
  logic [QUAD_W-1:0] qpos_reg, qpos_next;
  logic [QUAD_W-1:0] qdiv_reg, qdiv_next;
  logic qpulse_reg, qpulse_next;
  logic qstep;

  assign quad_a = src_signals[quad_a_input_pick];
  assign quad_b = src_signals[quad_b_input_pick];
  assign quad_clear = quad_soft_clear | src_rise[quad_clear_source];

  // step decoding under the chosen method
  quad_step_decoder u_decoder (
    .core_clk(core_clk),
    .rst(rst),
    .method(quad_counting_method),
    .restart(quad_clear),
    .quad_a(quad_a),
    .quad_b(quad_b),
    .step_fwd(step_fwd),
    .step_rev(step_rev)
  );

  // position, divider and pulse
  always_comb begin
    qpos_next = qpos_reg;
    qdiv_next = qdiv_reg;
    qpulse_next = 1'b0;
    qstep = 1'b0;
    if (quad_clear) begin
      qpos_next = '0;
      qdiv_next = '0;
    end else if (quad_load) begin
      qpos_next = quad_load_value;
    end else if (step_fwd) begin
      qpos_next = qpos_reg + 32'h1;
      qstep = 1'b1;
    end else if (step_rev && quad_direction_policy == DIR_POLICY_POSITION) begin
      qpos_next = qpos_reg - 32'h1;
      qstep = 1'b1;
    end
    // reverse under direction policy holds the value
    if (qstep) begin
      if (qdiv_reg + 32'h1 >= quad_output_ratio) begin
        qpulse_next = 1'b1;
        qdiv_next = '0;
      end else begin
        qdiv_next = qdiv_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      qpos_reg <= '0;
      qdiv_reg <= '0;
      qpulse_reg <= 1'b0;
    end else begin
      qpos_reg <= qpos_next;
      qdiv_reg <= qdiv_next;
      qpulse_reg <= qpulse_next;
    end
  end

  assign quad_position_count = qpos_reg;
  assign quad_output_pulse = qpulse_reg;

  // ---------------------------------------------------------------
  // event counter
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic cend_reg, cend_next;

  // count selected events, raise terminal event at target
  always_comb begin
    cnt_next = cnt_reg;
    cend_next = 1'b0;
    if (count_soft_clear || src_rise[count_clear_source]) begin
      cnt_next = '0;
    end else if (count_load) begin
      cnt_next = count_load_value;
    end else if (src_rise[count_increment_source]) begin
      cnt_next = cnt_reg + 32'h1;
      if (cnt_reg + 32'h1 == count_target_length) begin
        cend_next = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg <= '0;
      cend_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      cend_reg <= cend_next;
    end
  end

  assign count_present_value = cnt_reg;
  assign count_terminal_event = cend_reg;

  // ---------------------------------------------------------------
  // delay and pulse timer
  // ---------------------------------------------------------------
  tmr_state_t tst_reg, tst_next;
  logic [7:0] tick_reg, tick_next;
  logic [TMR_W-1:0] tval_reg, tval_next;
  logic tact_reg, tact_next;
  logic us_tick;

  assign us_tick = (tick_reg == US_TICK_LAST);

  // delay phase then pulse phase, value in microseconds
  always_comb begin
    tst_next = tst_reg;
    tval_next = tval_reg;
    tick_next = us_tick ? 8'h0 : 8'(tick_reg + 8'h1);
    tact_next = 1'b0;
    if (tmr_soft_clear) begin
      tst_next = TMR_DELAY;
      tval_next = '0;
      tick_next = 8'h0;
    end else if (tmr_load) begin
      tval_next = tmr_load_value;
    end else begin
      case (tst_reg)
        TMR_IDLE: begin
          tick_next = 8'h0;
          if (src_rise[tmr_start_source]) begin
            tst_next = TMR_DELAY;
            tval_next = '0;
          end
        end
        TMR_DELAY: begin
          if (tval_reg >= tmr_start_delay_us) begin
            tst_next = TMR_PULSE;
            tval_next = '0;
            tick_next = 8'h0;
          end else if (us_tick) begin
            tval_next = tval_reg + 32'h1;
          end
        end
        TMR_PULSE: begin
          tact_next = 1'b1;
          if (tval_reg >= tmr_pulse_length_us) begin
            tst_next = TMR_IDLE;
            tact_next = 1'b0;
          end else if (us_tick) begin
            tval_next = tval_reg + 32'h1;
          end
        end
        default: begin
          tst_next = TMR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tst_reg <= TMR_IDLE;
      tick_reg <= 8'h0;
      tval_reg <= '0;
      tact_reg <= 1'b0;
    end else begin
      tst_reg <= tst_next;
      tick_reg <= tick_next;
      tval_reg <= tval_next;
      tact_reg <= tact_next;
    end
  end

  assign tmr_present_value_us = tval_reg;
  assign tmr_active = tact_reg;

  // ---------------------------------------------------------------
  // logic cell
  // ---------------------------------------------------------------
  logic [3:0] lut_reg, lut_next;
  logic cell_reg, cell_next;
  logic [CELL_INPUTS-1:0] cell_in;
  logic lut_rd_reg, lut_rd_next;
  logic [1:0] incnt_reg, incnt_next;

  // picked and optionally negated inputs, index 1 is a
  generate
    for (gi = 0; gi < CELL_INPUTS; gi++) begin : g_cell_in
      assign cell_in[gi] =
        src_signals[cell_input_pick[gi*SRC_W +: SRC_W]] ^ cell_input_negate[gi];
    end
  endgenerate

  // table writes and combining function
  always_comb begin
    lut_next = lut_reg;
    if (truth_table_all_write) begin
      lut_next = truth_table_all_bits;
    end else if (truth_table_entry_write) begin
      lut_next[truth_table_entry_index] = truth_table_entry_bit;
    end
    lut_rd_next = lut_next[truth_table_entry_index];
    incnt_next = CELL_INPUT_COUNT;
    case (cell_combine_function)
      CELL_AND: cell_next = cell_in[1] & cell_in[0];
      CELL_OR: cell_next = cell_in[1] | cell_in[0];
      CELL_TABLE: cell_next = lut_reg[{cell_in[1], cell_in[0]}];
      default: cell_next = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lut_reg <= TRUTH_TABLE_RESET;
      lut_rd_reg <= 1'b0;
      incnt_reg <= CELL_INPUT_COUNT;
      cell_reg <= 1'b0;
    end else begin
      lut_reg <= lut_next;
      lut_rd_reg <= lut_rd_next;
      incnt_reg <= incnt_next;
      cell_reg <= cell_next;
    end
  end

  assign truth_table_value = lut_reg;
  assign truth_table_read_bit = lut_rd_reg;
  assign cell_active_input_count = incnt_reg;
  assign cell_output = cell_reg;

endmodule

// file: src/quad_step_decoder.sv
// quadrature a/b step decoder with two counting methods
`timescale 1ns/1ps
module quad_step_decoder
  import trig_logic_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // control
  input wire logic method,
  input wire logic restart,
  // encoder lines
  input wire logic quad_a,
  input wire logic quad_b,
  // steps out
  output logic step_fwd,
  output logic step_rev
);

  logic [1:0] prev_reg, prev_next;
  logic [1:0] phase_reg, phase_next;
  logic fwd_reg, fwd_next;
  logic rev_reg, rev_next;
  logic [1:0] cur;
  logic [1:0] cur_pos, prev_pos;
  logic [1:0] diff;

  // gray position of a/b in sequence 00 10 11 01
  function automatic logic [1:0] gray_pos(input logic [1:0] ab);
    case (ab)
      2'b00: gray_pos = 2'h0;
      2'b10: gray_pos = 2'h1;
      2'b11: gray_pos = 2'h2;
      default: gray_pos = 2'h3;
    endcase
  endfunction

  assign cur = {quad_a, quad_b};
  assign step_fwd = fwd_reg;
  assign step_rev = rev_reg;

  // next step from sampled phase change
  always_comb begin
    prev_next = cur;
    phase_next = phase_reg;
    fwd_next = 1'b0;
    rev_next = 1'b0;
    cur_pos = gray_pos(cur);
    prev_pos = gray_pos(prev_reg);
    diff = 2'(cur_pos - prev_pos);
    if (restart) begin
      phase_next = 2'h0;
    end else if (method == EVERY_EDGE_COUNTING) begin
      fwd_next = (diff == 2'h1);
      rev_next = (diff == 2'h3);
    end else begin
      // net phase accumulator, jitter back and forth cancels
      if (diff == 2'h1) begin
        phase_next = 2'(phase_reg + 2'h1);
        fwd_next = (phase_reg == 2'h3);
      end else if (diff == 2'h3) begin
        phase_next = 2'(phase_reg - 2'h1);
        rev_next = (phase_reg == 2'h0);
      end
    end
  end

  // register decoder state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      prev_reg <= 2'h0;
      phase_reg <= 2'h0;
      fwd_reg <= 1'b0;
      rev_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      phase_reg <= phase_next;
      fwd_reg <= fwd_next;
      rev_reg <= rev_next;
    end
  end

endmodule

// file: src/trig_logic_pkg.sv
// constants and types shared by the trigger-processing logic
package trig_logic_pkg;

  // signal source selection
  localparam int SRC_W = 3;
  localparam int NUM_SRC = 8;

  // counter, timer and encoder position widths
  localparam int CNT_W = 32;
  localparam int TMR_W = 32;
  localparam int QUAD_W = 32;

  // one microsecond tick at 10 MHz
  localparam int CLK_FREQ_MHZ = 10;
  localparam int US_TICK_NS = 1000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int US_TICK_CYCLES = US_TICK_NS / CLK_PERIOD_NS;
  localparam logic [7:0] US_TICK_LAST = 8'(US_TICK_CYCLES - 1);

  // encoder input rate limit held by the far side
  localparam int QUAD_MAX_RATE_KHZ = 30;

  // logic cell
  localparam int CELL_INPUTS = 2;
  localparam logic [1:0] CELL_INPUT_COUNT = 2'h2;
  localparam logic [3:0] TRUTH_TABLE_RESET = 4'h0;

  // reset values
  localparam logic [31:0] RATIO_RESET = 32'h0000_0001;

  // counting method
  typedef enum logic [0:0] {
    FULL_CYCLE_COUNTING = 1'b0,
    EVERY_EDGE_COUNTING = 1'b1
  } quad_method_t;

  // direction policy
  typedef enum logic [0:0] {
    DIR_POLICY_DIRECTION = 1'b0,
    DIR_POLICY_POSITION = 1'b1
  } quad_policy_t;

  // logic cell function
  typedef enum logic [1:0] {
    CELL_AND = 2'b00,
    CELL_OR = 2'b01,
    CELL_TABLE = 2'b10
  } cell_func_t;

  // timer sequence
  typedef enum logic [1:0] {
    TMR_IDLE = 2'b00,
    TMR_DELAY = 2'b01,
    TMR_PULSE = 2'b10
  } tmr_state_t;

endpackage
